// [design/lcd_consts.svh]
// constants for the segment/common display driver: offsets, fields, resets, levels
// assumes a 16-bit register port with a 5-bit word address
`ifndef LCD_CONSTS_SVH
`define LCD_CONSTS_SVH
// register word addresses
`define LCD_ADDR_CTRL 5'h00
`define LCD_ADDR_COMSEL 5'h01
`define LCD_ADDR_SEGSEL 5'h02
`define LCD_ADDR_STATUS 5'h03
`define LCD_ADDR_MEM_HI 1'b1
// display control fields
`define LCD_CTRL_FP_LO 0
`define LCD_CTRL_FP_HI 1
`define LCD_CTRL_DUTY_LO 2
`define LCD_CTRL_DUTY_HI 3
`define LCD_CTRL_BLANK 4
`define LCD_CTRL_INTERNAL_DIVIDER_CONNECT 5
`define LCD_CTRL_RUN_IN_WATCH_MODE 6
`define LCD_CTRL_CSS 7
`define LCD_CTRL_RESET 8'h10
// pin select fields, in bits 8 and up of the data word
`define LCD_COMSEL_LO 8
`define LCD_COMSEL_HI 11
`define LCD_SEGSEL_LO 8
`define LCD_SEGSEL_HI 13
`define LCD_COMSEL_RESET 4'h0
`define LCD_SEGSEL_RESET 6'h00
// prescaler base divisor, frame select shifts it left
`define LCD_BASE_DIV 16'h0040
// drive level codes, one-third bias: V0 lowest, V3 highest
`define LCD_LVL_V0 2'h0
`define LCD_LVL_V1 2'h1
`define LCD_LVL_V2 2'h2
`define LCD_LVL_V3 2'h3
`endif

// [design/lcd_pkg.sv]
// types shared by the display driver files
// assumes nothing beyond a SystemVerilog compiler
package lcd_pkg;
  typedef enum logic [1:0] {
    LCD_DUTY_STOP = 2'b00,
    LCD_DUTY_HALF = 2'b01,
    LCD_DUTY_THIRD = 2'b10,
    LCD_DUTY_QUARTER = 2'b11
  } lcd_duty_t;
  typedef enum logic {
    LCD_ST_IDLE = 1'b0,
    LCD_ST_RUN = 1'b1
  } lcd_state_t;
endpackage

// [design/lcd_disp_mem.sv]
// sixteen-byte display memory with a byte port for software and a column port
// assumes one clock, active-low async reset and a clock enable that freezes it
`timescale 1ns/10ps
`default_nettype none
module lcd_disp_mem (
  // clock and reset
  input wire logic clk_sys,
  input wire logic rst_n,
  input wire logic ce,
  // software byte port
  input wire logic wrEn,
  input wire logic [3:0] wrAddr,
  input wire logic [7:0] wrData,
  input wire logic [3:0] rdAddr,
  output logic [7:0] rdData,
  // column port: one bit per segment for the chosen common
  input wire logic [1:0] colSel,
  output logic [31:0] colData
);
  logic [7:0] mem_r [16];

  // segment s of common c lives in byte s/2, bit 4*(s%2)+c
  function automatic logic [31:0] gatherCol(input logic [1:0] c);
    logic [31:0] v;
    v = 32'h0000_0000;
    for (int s = 0; s < 32; s++)
    begin
      v[s] = mem_r[s / 2][(s % 2) * 4 + int'(c)];
    end
    return v;
  endfunction

  // storage
  always_ff @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
    begin
      for (int i = 0; i < 16; i++)
      begin
        mem_r[i] <= 8'h00;
      end
    end
    else if (ce && wrEn)
    begin
      mem_r[wrAddr] <= wrData;
    end
  end

  // registered read ports
  always_ff @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
    begin
      rdData <= 8'h00;
      colData <= 32'h0000_0000;
    end
    else if (ce)
    begin
      rdData <= mem_r[rdAddr];
      colData <= gatherCol(colSel);
    end
  end
endmodule
`default_nettype wire

// [design/lcd_seg_com_driver.sv]
// multiplexed segment/common driver for a passive display panel
// assumes tick inputs synchronous to clk_sys, and an outside pin mux and analog divider
// Function
// - four common and thirty-two segment drive outputs
// - sixteen-byte memory scanned onto segment outputs
// - half, third, quarter duty; one-third bias
// - duty sets which common lines scan
// - main or sub clock feeds drive timing
// - prescaler divides chosen clock into frame cycle
// - common and segment timing aligned to frame
// - alternating waveform for AC panel drive
// - control register picks clock, divider, blank, duty, cycle
// - commons and segments 8-31 releasable to ports
// - segments 0-7 always segment outputs
// - partner group ports become output-only
// - common select bits 8-11, one selects common
// - port common output-only when another selected
// - common select bits 12-15 unwritable, read undefined
// - duty zero stops display, outputs low
// - blanking drives non-select segment waveforms
// - clock select zero main, one sub
// - watch mode suspends display unless run bit
//
// The plain strobed port and the register addresses were left to the implementer.
`include "lcd_consts.svh"
`timescale 1ns/10ps
`default_nettype none
module lcd_seg_com_driver #(
  parameter logic [15:0] BASE_DIV = `LCD_BASE_DIV
) (
  // clock, reset, enable
  input wire logic clk_sys,
  input wire logic rst_n,
  input wire logic ce,
  // register port
  input wire logic [4:0] regAddr,
  input wire logic [15:0] regWrData,
  input wire logic regWr,
  input wire logic regRd,
  output logic [15:0] regRdData,
  // clock sources and power mode
  input wire logic mainOscTick,
  input wire logic subClkTick,
  input wire logic watchMode,
  // drive level codes, two bits per line
  output logic [7:0] comLevel,
  output logic [63:0] segLevel,
  // pin function to the port mux
  output logic [3:0] comEnable,
  output logic [3:0] comPortInEn,
  output logic [31:0] segEnable,
  output logic [31:0] segPortInEn,
  output logic dividerConnect
);
  logic [7:0] ctrl_r;
  logic [3:0] comSel_r;
  logic [5:0] segSel_r;
  logic [15:0] preCnt_r;
  logic [1:0] comIdx_r;
  logic [1:0] comIdxD_r;
  logic phase_r;
  logic phaseD_r;
  lcd_pkg::lcd_state_t state_r;
  lcd_pkg::lcd_state_t state_nxt;
  logic [15:0] regRd_r;
  logic memRdSel_r;
  logic [7:0] memRdData;
  logic [31:0] colData;
  logic [15:0] preTerm;
  logic srcTick;
  logic slotTick;
  logic active;
  logic lastCom;
  lcd_pkg::lcd_duty_t duty;
  logic blank;
  logic memWr;

  // one-third bias level for a line in a phase; phase one mirrors the swing
  function automatic logic [1:0] biasLevel(input logic isCom, input logic sel,
                                            input logic ph);
    logic [1:0] b;
    b = isCom ? (sel ? `LCD_LVL_V3 : `LCD_LVL_V1) : (sel ? `LCD_LVL_V0 : `LCD_LVL_V2);
    return ph ? (`LCD_LVL_V3 - b) : b;
  endfunction

  // register field views
  assign duty = lcd_pkg::lcd_duty_t'(ctrl_r[`LCD_CTRL_DUTY_HI:`LCD_CTRL_DUTY_LO]);
  assign blank = ctrl_r[`LCD_CTRL_BLANK];
  assign dividerConnect = ctrl_r[`LCD_CTRL_INTERNAL_DIVIDER_CONNECT];
  assign memWr = regWr && regAddr[4] == `LCD_ADDR_MEM_HI;

  // run unless stopped by duty or by watch mode without the run bit
  assign active = duty != lcd_pkg::LCD_DUTY_STOP
    && !(watchMode && !ctrl_r[`LCD_CTRL_RUN_IN_WATCH_MODE]);

  // register writes; the upper common select bits are never stored
  always_ff @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
    begin
      ctrl_r <= `LCD_CTRL_RESET;
      comSel_r <= `LCD_COMSEL_RESET;
      segSel_r <= `LCD_SEGSEL_RESET;
    end
    else if (ce && regWr)
    begin
      case (regAddr)
        `LCD_ADDR_CTRL: ctrl_r <= regWrData[7:0];
        `LCD_ADDR_COMSEL: comSel_r <= regWrData[`LCD_COMSEL_HI:`LCD_COMSEL_LO];
        `LCD_ADDR_SEGSEL: segSel_r <= regWrData[`LCD_SEGSEL_HI:`LCD_SEGSEL_LO];
        default: ;
      endcase
    end
  end

  // read data stand one cycle after the strobe; unmapped reads give zero
  always_ff @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
    begin
      regRd_r <= 16'h0000;
      memRdSel_r <= 1'b0;
    end
    else if (ce)
    begin
      memRdSel_r <= regRd && regAddr[4] == `LCD_ADDR_MEM_HI;
      if (regRd)
      begin
        case (regAddr)
          `LCD_ADDR_CTRL: regRd_r <= {8'h00, ctrl_r};
          `LCD_ADDR_COMSEL: regRd_r <= {4'h0, comSel_r, 8'h00};
          `LCD_ADDR_SEGSEL: regRd_r <= {2'h0, segSel_r, 8'h00};
          `LCD_ADDR_STATUS: regRd_r <= {12'h000, state_r, phase_r, comIdx_r};
          default: regRd_r <= 16'h0000;
        endcase
      end
      else
      begin
        regRd_r <= 16'h0000;
      end
    end
  end
  assign regRdData = memRdSel_r ? {8'h00, memRdData} : regRd_r;

  // display memory, scanned one common column at a time
  lcd_disp_mem u_mem (
    .clk_sys(clk_sys),
    .rst_n(rst_n),
    .ce(ce),
    .wrEn(memWr),
    .wrAddr(regAddr[3:0]),
    .wrData(regWrData[7:0]),
    .rdAddr(regAddr[3:0]),
    .rdData(memRdData),
    .colSel(comIdx_r),
    .colData(colData)
  );

  // source select and prescaler; the slot tick ends one common period
  assign srcTick = ctrl_r[`LCD_CTRL_CSS] ? subClkTick : mainOscTick;
  assign preTerm = 16'(BASE_DIV << ctrl_r[`LCD_CTRL_FP_HI:`LCD_CTRL_FP_LO]) - 16'h0001;
  assign slotTick = state_r == lcd_pkg::LCD_ST_RUN && srcTick && preCnt_r >= preTerm;
  assign lastCom = comIdx_r >= duty; // >= wraps at once when duty shrinks

  // prescaler count, held clear while idle so each start is clean
  always_ff @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
    begin
      preCnt_r <= 16'h0000;
    end
    else if (ce)
    begin
      if (state_r != lcd_pkg::LCD_ST_RUN || slotTick)
      begin
        preCnt_r <= 16'h0000;
      end
      else if (srcTick)
      begin
        preCnt_r <= preCnt_r + 16'h0001;
      end
    end
  end

  // run state follows duty and watch mode
  always_comb
  begin
    case (state_r)
      lcd_pkg::LCD_ST_IDLE: state_nxt = active ? lcd_pkg::LCD_ST_RUN : lcd_pkg::LCD_ST_IDLE;
      lcd_pkg::LCD_ST_RUN: state_nxt = active ? lcd_pkg::LCD_ST_RUN : lcd_pkg::LCD_ST_IDLE;
      default: state_nxt = lcd_pkg::LCD_ST_IDLE;
    endcase
  end

  always_ff @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
    begin
      state_r <= lcd_pkg::LCD_ST_IDLE;
    end
    else if (ce)
    begin
      state_r <= state_nxt;
    end
  end

  // common scan and frame polarity; polarity flips after the last common
  always_ff @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
    begin
      comIdx_r <= 2'h0;
      phase_r <= 1'b0;
    end
    else if (ce)
    begin
      if (state_r != lcd_pkg::LCD_ST_RUN)
      begin
        comIdx_r <= 2'h0;
        phase_r <= 1'b0;
      end
      else if (slotTick)
      begin
        comIdx_r <= lastCom ? 2'h0 : comIdx_r + 2'h1;
        phase_r <= lastCom ? !phase_r : phase_r;
      end
    end
  end

  // delay index and phase one cycle to line up with the registered column
  always_ff @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
    begin
      comIdxD_r <= 2'h0;
      phaseD_r <= 1'b0;
    end
    else if (ce)
    begin
      comIdxD_r <= comIdx_r;
      phaseD_r <= phase_r;
    end
  end

  // common drive; commons beyond the duty stay at non-select level
  always_ff @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
    begin
      comLevel <= 8'h00;
    end
    else if (ce)
    begin
      for (int c = 0; c < 4; c++)
      begin
        if (state_r != lcd_pkg::LCD_ST_RUN)
        begin
          comLevel[c * 2 +: 2] <= `LCD_LVL_V0;
        end
        else
        begin
          comLevel[c * 2 +: 2] <= biasLevel(1'b1, comIdxD_r == 2'(c), phaseD_r);
        end
      end
    end
  end

  // segment drive; blanking forces the off waveform but timing runs on
  always_ff @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
    begin
      segLevel <= 64'h0000_0000_0000_0000;
    end
    else if (ce)
    begin
      for (int s = 0; s < 32; s++)
      begin
        if (state_r != lcd_pkg::LCD_ST_RUN)
        begin
          segLevel[s * 2 +: 2] <= `LCD_LVL_V0;
        end
        else
        begin
          segLevel[s * 2 +: 2] <= biasLevel(1'b0, colData[s] && !blank, phaseD_r);
        end
      end
    end
  end

  // common pin function: port pins lose input once any other common is used
  always_comb
  begin
    comEnable = comSel_r;
    for (int c = 0; c < 4; c++)
    begin
      comPortInEn[c] = comSel_r == 4'h0;
    end
  end

  // segment pin groups of four; groups pair as (0,1), (2,3), (4,5)
  always_comb
  begin
    segEnable = 32'h0000_00ff;
    segPortInEn = 32'h0000_0000;
    for (int g = 0; g < 6; g++)
    begin
      // groups 4 and 5 hold segments 8-15, groups 0-3 hold 16-31
      int base;
      base = (g >= 4) ? (g - 4) * 4 + 8 : g * 4 + 16;
      segEnable[base +: 4] = {4{segSel_r[g]}};
      segPortInEn[base +: 4] = {4{!segSel_r[g] && !segSel_r[g ^ 1]}};
    end
  end

  // checks
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rst_n);

  sequence sLastSlot;
    ce && slotTick && lastCom;
  endsequence

  sequence sMidSlot;
    ce && slotTick && !lastCom;
  endsequence

  chk_stop_outputs_low: assert property (
    ce && state_r == lcd_pkg::LCD_ST_IDLE |=> comLevel == 8'h00 && segLevel == 64'h0)
    else $error("outputs not low while stopped");

  chk_scan_wraps: assert property (
    sLastSlot |=> comIdx_r == 2'h0)
    else $error("common scan did not wrap at duty end");

  chk_frame_flip: assert property (
    sLastSlot |=> phase_r != $past(phase_r))
    else $error("polarity did not flip at frame end");

  chk_phase_steady: assert property (
    sMidSlot |=> $stable(phase_r) && comIdx_r == $past(comIdx_r) + 2'h1)
    else $error("polarity changed inside a frame");

  chk_unused_com_nonsel: assert property (
    ce && state_r == lcd_pkg::LCD_ST_RUN && duty == lcd_pkg::LCD_DUTY_HALF
    ##1 ce && state_r == lcd_pkg::LCD_ST_RUN
    |=> comLevel[7:6] == `LCD_LVL_V1 || comLevel[7:6] == `LCD_LVL_V2)
    else $error("unused common left the non-select level");

  chk_blank_segs: assert property (
    ce && state_r == lcd_pkg::LCD_ST_RUN && blank
    |=> segLevel[1:0] == `LCD_LVL_V1 || segLevel[1:0] == `LCD_LVL_V2)
    else $error("segment selected while blanked");

  chk_com_upper_read: assert property (
    ce && regRd && regAddr == `LCD_ADDR_COMSEL |=> regRdData[15:12] == 4'h0
      && regRdData[11:8] == $past(comSel_r))
    else $error("common select read back wrong");

  chk_com_port_output: assert property (
    comPortInEn == (comSel_r == 4'h0 ? 4'hf : 4'h0))
    else $error("common port input enable wrong");

  chk_watch_suspend: assert property (
    ce && watchMode && !ctrl_r[`LCD_CTRL_RUN_IN_WATCH_MODE] |=> state_r == lcd_pkg::LCD_ST_IDLE)
    else $error("display kept running in watch mode");

  chk_fixed_segs: assert property (
    segEnable[7:0] == 8'hff)
    else $error("fixed segment pins released");
endmodule
`default_nettype wire

// [dv/lcd_panel_model.sv]
// panel model: marks pixels that see full drive and the polarities seen on common 0
// assumes two-bit level codes, V0..V3, one-third bias
`timescale 1ns/10ps
`default_nettype none
module lcd_panel_model (
  // clock and reset
  input wire logic clk_sys,
  input wire logic rst_n,
  // drive levels and a clear from the bench
  input wire logic clr,
  input wire logic [7:0] comLevel,
  input wire logic [63:0] segLevel,
  // what the glass saw
  output logic [127:0] litMap,
  output logic [1:0] polSeen
);
  // only the full three-step swing lights a pixel; partial swings stay dark
  always_ff @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
    begin
      litMap <= '0;
      polSeen <= 2'h0;
    end
    else if (clr)
    begin
      litMap <= '0;
      polSeen <= 2'h0;
    end
    else
    begin
      for (int c = 0; c < 4; c++)
        for (int s = 0; s < 32; s++)
          if ({comLevel[2*c +: 2], segLevel[2*s +: 2]} inside {4'hc, 4'h3})
            litMap[c*32+s] <= 1'b1;
      // both selected polarities must appear, or the glass sees dc
      if (comLevel[1:0] == 2'h3)
        polSeen[0] <= 1'b1;
      // mirrored select: common 0 low while its segment is off the low rail
      if (comLevel[1:0] == 2'h0 && segLevel[1:0] != 2'h0)
        polSeen[1] <= 1'b1;
    end
  end
endmodule
`default_nettype wire

// [dv/lcd_seg_com_driver_tb_top.sv]
// self-checking bench for the segment/common driver with a panel model
// assumes the design's constants header and a short prescaler base
`include "lcd_consts.svh"
`timescale 1ns/10ps
`default_nettype none
module lcd_seg_com_driver_tb_top;
  logic clk_sys = 1'b0;
  logic rst_n = 1'b0;
  logic ce = 1'b1;
  logic [4:0] regAddr = 5'h00;
  logic [15:0] regWrData = 16'h0000;
  logic regWr = 1'b0;
  logic regRd = 1'b0;
  logic [15:0] regRdData;
  logic mainOscTick = 1'b0;
  logic subClkTick = 1'b0;
  logic watchMode = 1'b0;
  logic [7:0] comLevel;
  logic [63:0] segLevel;
  logic [3:0] comEnable;
  logic [3:0] comPortInEn;
  logic [31:0] segEnable;
  logic [31:0] segPortInEn;
  logic dividerConnect;
  logic clr = 1'b0;
  logic [127:0] litMap;
  logic [1:0] polSeen;
  logic mainEn = 1'b0;
  logic subEn = 1'b0;
  logic fullRate = 1'b0;
  logic [7:0] mem [16];
  int failures = 0;
  int compares = 0;

  always #5 clk_sys = ~clk_sys;

  lcd_seg_com_driver #(.BASE_DIV(16'h0002)) i_lcd_seg_com_driver (.clk_sys(clk_sys),
    .rst_n(rst_n), .ce(ce), .regAddr(regAddr), .regWrData(regWrData), .regWr(regWr),
    .regRd(regRd), .regRdData(regRdData), .mainOscTick(mainOscTick),
    .subClkTick(subClkTick), .watchMode(watchMode), .comLevel(comLevel),
    .segLevel(segLevel), .comEnable(comEnable), .comPortInEn(comPortInEn),
    .segEnable(segEnable), .segPortInEn(segPortInEn), .dividerConnect(dividerConnect));
  lcd_panel_model i_lcd_panel_model (.clk_sys(clk_sys), .rst_n(rst_n), .clr(clr),
    .comLevel(comLevel), .segLevel(segLevel), .litMap(litMap), .polSeen(polSeen));

  // tick sources: random pulse trains, or every cycle when timing is measured
  always @(posedge clk_sys)
  begin
    mainOscTick <= mainEn & (fullRate | (($urandom % 2) == 1));
    subClkTick <= subEn & (fullRate | (($urandom % 2) == 1));
  end

  task automatic chk(input string name, input logic [127:0] seen, input logic [127:0] exp);
    compares++;
    if (seen !== exp)
    begin
      failures++;
      $display("BAD %s expected %h seen %h", name, exp, seen);
    end
  endtask

  task automatic test_done;
    if (failures == 0 && compares > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask

  task automatic wr(input logic [4:0] a, input logic [15:0] d);
    @(posedge clk_sys);
    regAddr <= a;
    regWrData <= d;
    regWr <= 1'b1;
    @(posedge clk_sys);
    regWr <= 1'b0;
  endtask

  // read data stand only in the cycle after the strobe
  task automatic rd(input logic [4:0] a, output logic [15:0] d);
    @(posedge clk_sys);
    regAddr <= a;
    regRd <= 1'b1;
    @(posedge clk_sys);
    regRd <= 1'b0;
    #1 d = regRdData;
  endtask

  // expected pin function: groups in select-bit order, partners are bit pairs
  function automatic logic [63:0] segExp(input logic [5:0] sel);
    logic [31:0] en;
    logic [31:0] pin;
    int b;
    en = 32'h0000_00ff;
    pin = 32'h0000_0000;
    for (int i = 0; i < 6; i++)
    begin
      b = (i < 4) ? 16 + 4 * i : 4 * i - 8;
      en[b +: 4] = {4{sel[i]}};
      pin[b +: 4] = {4{~sel[i] & ~sel[i ^ 1]}};
    end
    return {en, pin};
  endfunction

  function automatic logic [127:0] litExp(input int duty);
    logic [127:0] m;
    m = '0;
    for (int c = 0; c <= duty; c++)
      for (int s = 0; s < 32; s++)
        m[c*32+s] = mem[s/2][(s%2)*4+c];
    return m;
  endfunction

  // cycles between two level changes, zero if the scan stands still
  task automatic measure(output int per);
    logic [7:0] last;
    int n;
    per = 0;
    repeat (6) @(posedge clk_sys);
    #1 last = comLevel;
    for (n = 0; n < 60 && comLevel === last; n++)
      @(posedge clk_sys) #1;
    if (n == 60)
      return;
    last = comLevel;
    for (n = 1; n < 60 && per == 0; n++)
    begin
      @(posedge clk_sys) #1;
      if (comLevel !== last)
        per = n;
    end
  endtask

  task automatic scan(input logic [15:0] ctl);
    wr(`LCD_ADDR_CTRL, ctl);
    repeat (8) @(posedge clk_sys);
    clr <= 1'b1;
    @(posedge clk_sys);
    clr <= 1'b0;
    repeat (300) @(posedge clk_sys);
    #1;
  endtask

  initial
  begin
    repeat (100000) @(posedge clk_sys);
    failures++;
    test_done();
  end

  initial
  begin
    logic [15:0] d;
    logic [15:0] v;
    int per;
    void'($urandom(32'h2b45f0f1));
    repeat (8) @(posedge clk_sys);
    rst_n <= 1'b1;
    #1;
    chk("comEnable", comEnable, 4'h0);
    chk("comPortInEn", comPortInEn, 4'hf);
    chk("segPins", {segEnable, segPortInEn}, segExp(6'h00));
    chk("levels", {comLevel, segLevel}, 72'h0);
    rd(`LCD_ADDR_CTRL, v);
    chk("ctrlReset", v, 16'h0010);
    for (int i = 0; i < 8; i++)
    begin
      d = (i == 0) ? 16'hf100 : 16'($urandom);
      wr(`LCD_ADDR_COMSEL, d);
      rd(`LCD_ADDR_COMSEL, v);
      chk("comSel", v[15:8], {4'h0, d[11:8]});
      chk("comEnable", comEnable, d[11:8]);
      chk("comPortInEn", comPortInEn, (d[11:8] == 4'h0) ? 4'hf : 4'h0);
      d = 16'($urandom);
      wr(`LCD_ADDR_SEGSEL, d);
      rd(`LCD_ADDR_SEGSEL, v);
      chk("segSel", v, {2'h0, d[13:8], 8'h00});
      chk("segPins", {segEnable, segPortInEn}, segExp(d[13:8]));
    end
    for (int a = 4; a < 16; a++)
    begin
      wr(5'(a), 16'($urandom));
      rd(5'(a), v);
      chk("unmapped", v, 16'h0000);
    end
    for (int n = 0; n < 16; n++)
    begin
      mem[n] = 8'($urandom);
      wr({`LCD_ADDR_MEM_HI, 4'(n)}, {8'h00, mem[n]});
    end
    for (int n = 0; n < 16; n++)
    begin
      rd({`LCD_ADDR_MEM_HI, 4'(n)}, v);
      chk("memory", v[7:0], mem[n]);
    end
    // software hands all commons and segments 8-31 over to the display before scanning
    wr(`LCD_ADDR_COMSEL, 16'h0f00);
    wr(`LCD_ADDR_SEGSEL, 16'h3f00);
    mainEn <= 1'b1;
    for (int dt = 1; dt < 4; dt++)
    begin
      scan(16'(dt << 2));
      chk("pixels", litMap, litExp(dt));
      chk("polarity", polSeen, 2'h3);
    end
    scan(16'h001c);
    chk("blanked", litMap, 128'h0);
    wr(`LCD_ADDR_CTRL, 16'h0000);
    repeat (4) @(posedge clk_sys);
    #1 chk("stopped", {comLevel, segLevel}, 72'h0);
    rd(`LCD_ADDR_STATUS, v);
    chk("status", v, 16'h0000);
    wr(`LCD_ADDR_CTRL, 16'h0020);
    rd(`LCD_ADDR_CTRL, v);
    chk("ctrl", v, 16'h0020);
    chk("divider", dividerConnect, 1'b1);
    fullRate = 1'b1;
    for (int fp = 0; fp < 4; fp++)
    begin
      wr(`LCD_ADDR_CTRL, 16'(4 + fp));
      measure(per);
      chk("slot", per, 2 << fp);
    end
    mainEn = 1'b0;
    subEn = 1'b1;
    wr(`LCD_ADDR_CTRL, 16'h0084);
    measure(per);
    chk("subSlot", per, 2);
    wr(`LCD_ADDR_CTRL, 16'h0004);
    measure(per);
    chk("mainIdle", per, 0);
    @(posedge clk_sys);
    watchMode <= 1'b1;
    wr(`LCD_ADDR_CTRL, 16'h0084);
    repeat (4) @(posedge clk_sys);
    #1 chk("watchOff", {comLevel, segLevel}, 72'h0);
    wr(`LCD_ADDR_CTRL, 16'h00c4);
    measure(per);
    chk("watchRun", per, 2);
    rd(`LCD_ADDR_STATUS, v);
    chk("running", v[15:3], 13'h0001);
    // clock enable low must hold the drive levels where they stand
    @(posedge clk_sys);
    ce <= 1'b0;
    @(posedge clk_sys) #1 v[7:0] = comLevel;
    repeat (20) @(posedge clk_sys);
    ce <= 1'b1;
    #1 chk("frozen", comLevel, v[7:0]);
    measure(per);
    chk("resumed", per, 2);
    test_done();
  end
endmodule
`default_nettype wire
